// ---- tb_top.sv ----
// self-checking bench of the shift register block with its bus-side peer
// assumes design files, checker and peer compile ahead of it
`timescale 1ns/10ps
`default_nettype none
`include "usr_map.svh"

module tb_top;
    import usr_pkg::*;
    localparam int BUF = 2;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd, seed = 32'hdd6d;
    logic        pready, pslverr, err, stall = 0, mode_sel_lo = 0, mode_sel_hi = 0;
    logic        clear_n = 1, nar_sr_in = 0, nar_sl_in = 0, wide_sr_in = 0, wide_sl_in = 0;
    logic        oe_a_n = 1, oe_b_n = 1, snap_ready = 1, snap_valid, drive_en = 0;
    logic        first_stage_out, last_stage_out;
    logic [3:0]  nar_par_in = 0, nar_q;
    logic [7:0]  wide_io_in, wide_io_out, wide_io_oe_n, snap_data, drive_data = 0;
    logic [7:0]  exp_w = 0, exp_n = 0, exp_q[$];
    int          error_cnt = 0, total_checks = 0;

    always #50 pclk = ~pclk;

    usr_top #(.BUF_DEPTH(BUF)) u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .mode_sel_lo, .mode_sel_hi, .clear_n,
        .nar_sr_in, .nar_sl_in, .nar_par_in, .nar_q, .wide_io_in, .wide_io_out,
        .wide_io_oe_n, .oe_a_n, .oe_b_n, .wide_sr_in, .wide_sl_in, .first_stage_out,
        .last_stage_out, .snap_valid, .snap_ready, .snap_data);
    usr_bus_peer u_peer (.pclk(pclk), .dev_q(wide_io_out), .dev_oe_n(wide_io_oe_n),
        .drive_en(drive_en), .drive_data(drive_data), .bus(wide_io_in));

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd

    // next contents of a w-stage register
    function automatic logic [7:0] nxt(logic [7:0] q, logic [1:0] m, logic sr, logic sl,
                                       logic [7:0] p, int w);
        logic [7:0] r;
        r = q;
        case (m)
            `USR_MODE_SHR: r = {q[6:0], sr};
            `USR_MODE_SHL: begin
                r = q >> 1;
                r[w-1] = sl;
            end
            `USR_MODE_LOAD: r = p;
            default: r = q;
        endcase
        return r & ((8'h01 << w) - 8'h01);
    endfunction : nxt

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic test_done();
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : test_done

    // one apb transfer, released only after pready is seen
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // one cycle of mode m on the pins, expectation advanced alongside
    task automatic cyc(input logic [1:0] m, input logic [31:0] r);
        @(posedge pclk);
        {mode_sel_hi, mode_sel_lo} <= m;
        {wide_sl_in, wide_sr_in, nar_sl_in, nar_sr_in} <= r[3:0];
        nar_par_in <= r[7:4];
        drive_data <= r[15:8];
        exp_n = nxt(exp_n, m, r[0], r[1], {4'h0, r[7:4]}, 4);
        if (m != `USR_MODE_HOLD && (snap_ready || exp_q.size() < BUF || !stall)) begin
            exp_w = nxt(exp_w, m, r[2], r[3], r[15:8], 8);
            if (snap_ready || exp_q.size() < BUF) exp_q.push_back(exp_w);
        end
    endtask : cyc

    task automatic hold6();
        repeat (6) cyc(`USR_MODE_HOLD, rnd());
    endtask : hold6

    // stream consumer: each popped word must be the oldest expected one
    always @(posedge pclk) begin
        if (clear_n && snap_valid === 1'b1 && snap_ready === 1'b1) begin
            chk({24'h0, snap_data}, exp_q.size() != 0 ? {24'h0, exp_q.pop_front()} : 32'hx);
        end
    end

    initial begin
        #(100 * 20000);
        error_cnt++;
        $display("mismatch at %0t: run timed out", $time);
        test_done();
    end

    initial begin
        repeat (20) @(posedge pclk);
        chk({nar_q, wide_io_out, wide_io_oe_n}, 32'h0000ff);
        presetn <= 1'b1;
        apb(0, `USR_CTRL_OFF, 0);
        chk(rd, `USR_CTRL_RST);
        apb(1, `USR_CTRL_OFF, 32'h6);
        apb(0, `USR_CTRL_OFF, 0);
        chk(rd, 32'h6);
        apb(1, `USR_CTRL_OFF, 0);
        apb(1, 12'h008, 32'hffffffff);
        chk({31'h0, err}, 1);
        apb(0, 12'h008, 0);
        chk({err, rd[30:0]}, 32'h80000000);
        $display("register test done");
        drive_en <= 1'b1;
        for (int m = 0; m < 4; m++) begin
            rd = rnd();
            repeat (6) cyc(m[1:0], rd);
        end
        repeat (12) begin
            rd = rnd();
            repeat (1 + rd[10:8] % 6) cyc(rd[1:0], rnd());
        end
        hold6();
        chk({nar_q, wide_io_out}, {exp_n[3:0], exp_w});
        chk({first_stage_out, last_stage_out}, {exp_w[0], exp_w[7]});
        apb(0, `USR_STAT_OFF, 0);
        chk(rd, {20'h0, exp_n[3:0], exp_w});
        $display("mode test done");
        for (int s = 0; s < 2; s++) begin
            stall = s[0];
            apb(1, `USR_CTRL_OFF, {28'h0, stall, 3'h0});
            snap_ready <= 1'b0;
            repeat (3) cyc(`USR_MODE_LOAD, rnd());
            hold6();
            chk(wide_io_out, exp_w);
            apb(0, `USR_STAT_OFF, 0);
            chk(rd[17:16], {1'b1, ~stall});
            apb(1, `USR_STAT_OFF, 32'h10000);
            snap_ready <= 1'b1;
            hold6();
            apb(0, `USR_STAT_OFF, 0);
            chk({30'h0, rd[17:16]}, 0);
            chk(exp_q.size(), 0);
        end
        $display("buffer test done");
        drive_en <= 1'b0;
        oe_a_n <= 1'b0;
        oe_b_n <= 1'b0;
        hold6();
        chk({wide_io_oe_n, wide_io_in}, {8'h00, exp_w});
        apb(0, `USR_STAT_OFF, 0);
        chk(rd[18], 1);
        oe_b_n <= 1'b1;
        repeat (3) cyc(`USR_MODE_SHR, rnd());
        hold6();
        chk({wide_io_oe_n, wide_io_out}, {8'hff, exp_w});
        $display("enable test done");
        @(posedge pclk);
        clear_n <= 1'b0;
        #10;
        chk({nar_q, wide_io_out}, 0);
        @(posedge pclk);
        clear_n <= 1'b1;
        exp_q.delete();
        $display("clear test done");
        test_done();
    end
endmodule : tb_top

bind usr_top usr_chk #(.SYNC_CLR(SYNC_CLR)) u_chk (.pclk, .presetn, .mode_sel_lo,
    .mode_sel_hi, .clear_n, .nar_par_in, .nar_q, .wide_io_out, .wide_io_oe_n, .oe_a_n,
    .oe_b_n, .first_stage_out, .last_stage_out);
`default_nettype wire

// ---- usr_buf2.sv ----
// small circular buffer with valid and ready on both sides
// assumes one clock; depth is at least two
`timescale 1ns/10ps
`default_nettype none

module usr_buf2 #(
    parameter int W     = 8,
    parameter int DEPTH = 2
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic      [W-1:0] out_data,
    output logic              full
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [AW-1:0]           wr;
        logic [AW-1:0]           rd;
        logic [CW-1:0]           cnt;
    } usr_buf_st_t;

    usr_buf_st_t st_q;
    usr_buf_st_t st_d;

    assign in_ready  = (st_q.cnt != CW'(DEPTH));
    assign out_valid = (st_q.cnt != '0);
    assign out_data  = st_q.mem[st_q.rd];
    assign full      = !in_ready;

    // push at write index, pop at read index
    always_comb begin
        logic push;
        logic pop;
        push = in_valid && in_ready;
        pop  = out_valid && out_ready;
        st_d = st_q;
        if (push) begin
            st_d.mem[st_q.wr] = in_data;
            st_d.wr = (st_q.wr == AW'(DEPTH - 1)) ? '0 : st_q.wr + 1'b1;
        end
        if (pop) begin
            st_d.rd = (st_q.rd == AW'(DEPTH - 1)) ? '0 : st_q.rd + 1'b1;
        end
        if (push && !pop) begin
            st_d.cnt = st_q.cnt + 1'b1;
        end else if (pop && !push) begin
            st_d.cnt = st_q.cnt - 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

endmodule : usr_buf2

`default_nettype wire

// ---- usr_bus_peer.sv ----
// bus-side system on the shared parallel pins of the wide register
// assumes the bench raises drive_en only while the output enables are inactive
`timescale 1ns/10ps
`default_nettype none

module usr_bus_peer (
    input  wire logic       pclk,
    input  wire logic [7:0] dev_q,
    input  wire logic [7:0] dev_oe_n,
    input  wire logic       drive_en,
    input  wire logic [7:0] drive_data,
    output logic      [7:0] bus
);
    logic [7:0] last_q = 8'h00;
    // wire level; contention is unknown, a released line shows the inverse of its last level
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (!dev_oe_n[i]) bus[i] = drive_en ? 1'bx : dev_q[i];
            else if (drive_en) bus[i] = drive_data[i];
            else bus[i] = ~last_q[i];
        end
    end
    // remembers the level of the previous cycle
    always @(posedge pclk) begin
        last_q <= bus;
    end
endmodule : usr_bus_peer
`default_nettype wire

// ---- usr_chk_assertions.sv ----
// assertion checker of the shift register block, on top ports only
// assumes pins change just after pclk edges and pass a short synchroniser
`timescale 1ns/10ps
`default_nettype none
`include "usr_map.svh"

module usr_chk #(
    parameter bit SYNC_CLR = 1'b0
) (
    input wire logic       pclk,
    input wire logic       presetn,
    input wire logic       mode_sel_lo,
    input wire logic       mode_sel_hi,
    input wire logic       clear_n,
    input wire logic [3:0] nar_par_in,
    input wire logic [3:0] nar_q,
    input wire logic [7:0] wide_io_out,
    input wire logic [7:0] wide_io_oe_n,
    input wire logic       oe_a_n,
    input wire logic       oe_b_n,
    input wire logic       first_stage_out,
    input wire logic       last_stage_out
);
    // one clock domain, reset aborts every attempt
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // mode pins and clear steady long enough to pass the synchroniser
    sequence s_mode(logic [1:0] m);
        ({mode_sel_hi, mode_sel_lo} == m && clear_n)[*5];
    endsequence

    property p_hold;
        s_mode(`USR_MODE_HOLD) |=> !clear_n || $stable(nar_q);
    endproperty
    a_hold: assert property (p_hold) else $error("narrow moved in hold");
    property p_shr;
        s_mode(`USR_MODE_SHR) |=> !clear_n || nar_q[3:1] == $past(nar_q[2:0]);
    endproperty
    a_shr: assert property (p_shr) else $error("narrow shift right wrong");
    property p_shl;
        s_mode(`USR_MODE_SHL) |=> !clear_n || nar_q[2:0] == $past(nar_q[3:1]);
    endproperty
    a_shl: assert property (p_shl) else $error("narrow shift left wrong");
    property p_load;
        ({mode_sel_hi, mode_sel_lo} == `USR_MODE_LOAD && clear_n && $stable(nar_par_in))[*5]
            |=> !clear_n || nar_q == $past(nar_par_in);
    endproperty
    a_load: assert property (p_load) else $error("narrow load wrong");
    property p_clr;
        !clear_n |-> nar_q == 4'h0 && (SYNC_CLR || wide_io_out == 8'h00);
    endproperty
    a_clr: assert property (p_clr) else $error("clear did not empty");
    property p_float;
        (oe_a_n || oe_b_n)[*5] |-> wide_io_oe_n == 8'hff;
    endproperty
    a_float: assert property (p_float) else $error("pins driven while disabled");
    property p_drive;
        (!oe_a_n && !oe_b_n)[*5] |-> wide_io_oe_n == 8'h00;
    endproperty
    a_drive: assert property (p_drive) else $error("pins not driven");
    property p_ends;
        wide_io_out[0] == first_stage_out && wide_io_out[7] == last_stage_out;
    endproperty
    a_ends: assert property (p_ends) else $error("end stage outputs wrong");
endmodule : usr_chk
`default_nettype wire

// ---- usr_map.svh ----
// constants of the universal shift and storage register block
// assumes inclusion by the package, the top module, the checker and the bench
//
// Function
// - two mode selects pick shift left, shift right, parallel load or hold.
// - besides clearing, state changes only on the rising clock edge.
// - active-low clear acts at once, without clock, and forces outputs low.
// - narrow variant has four bidirectional stages with serial and parallel entry.
// - wide variant has eight stages on shared three-state pins plus serial ports.
// - either output enable high floats the shared pins; operations go on.
// - optional wide variant clears synchronously, only at a rising clock edge.
// - wide variant gives separate first and last stage outputs for chaining.
`ifndef USR_MAP_SVH
`define USR_MAP_SVH

// mode encodings {mode_sel_hi, mode_sel_lo}
`define USR_MODE_HOLD       2'h0
`define USR_MODE_SHR        2'h1
`define USR_MODE_SHL        2'h2
`define USR_MODE_LOAD       2'h3

// apb register byte offsets
`define USR_CTRL_OFF        12'h000
`define USR_STAT_OFF        12'h004

// control register fields
`define USR_CTRL_OVR_BIT    0
`define USR_CTRL_MODE_LSB   1
`define USR_CTRL_STALL_BIT  3
`define USR_CTRL_RST        4'h0

// status register fields
`define USR_STAT_WIDE_LSB   0
`define USR_STAT_NAR_LSB    8
`define USR_STAT_DROP_BIT   16
`define USR_STAT_FULL_BIT   17
`define USR_STAT_DRV_BIT    18

// stage widths
`define USR_NAR_W           4
`define USR_WIDE_W          8

`endif

// ---- usr_pkg.sv ----
// types shared by the shift register block
// assumes usr_map.svh sits in the same folder
`include "usr_map.svh"

package usr_pkg;

    // operating mode of a register stage
    typedef enum logic [1:0] {
        USR_HOLD = `USR_MODE_HOLD,
        USR_SHR  = `USR_MODE_SHR,
        USR_SHL  = `USR_MODE_SHL,
        USR_LOAD = `USR_MODE_LOAD
    } usr_mode_t;

    // pin levels sampled by the synchroniser
    typedef struct packed {
        logic                    mode_sel_hi;
        logic                    mode_sel_lo;
        logic                    clear_n;
        logic                    nar_sr_in;
        logic                    nar_sl_in;
        logic                    wide_sr_in;
        logic                    wide_sl_in;
        logic [`USR_NAR_W-1:0]   nar_par;
        logic [`USR_WIDE_W-1:0]  wide_par;
        logic                    oe_a_n;
        logic                    oe_b_n;
    } usr_pins_t;

    // software control fields
    typedef struct packed {
        logic      stall_en;
        usr_mode_t mode;
        logic      ovr;
    } usr_ctrl_t;

endpackage : usr_pkg

// ---- usr_shreg.sv ----
// one parameterised shift and storage register
// assumes a free-running clock and an already combined asynchronous clear
`timescale 1ns/10ps
`default_nettype none

module usr_shreg #(
    parameter int W        = 8,
    parameter bit SYNC_CLR = 1'b0
) (
    input  wire logic             clk,
    input  wire logic             arst_n,
    input  wire logic             sync_clr,
    input  wire logic             stall,
    input  wire usr_pkg::usr_mode_t mode,
    input  wire logic             sr_in,
    input  wire logic             sl_in,
    input  wire logic [W-1:0]     par_in,
    output logic      [W-1:0]     q_next,
    output logic                  changing,
    output logic      [W-1:0]     q
);
    import usr_pkg::*;

    typedef struct packed {
        logic [W-1:0] q;
    } usr_shreg_st_t;

    usr_shreg_st_t st_q;
    usr_shreg_st_t st_d;

    // next contents by mode
    always_comb begin
        st_d = st_q;
        case (mode)
            USR_SHR:  st_d.q = {st_q.q[W-2:0], sr_in};
            USR_SHL:  st_d.q = {sl_in, st_q.q[W-1:1]};
            USR_LOAD: st_d.q = par_in;
            USR_HOLD: st_d.q = st_q.q;
            default:  st_d.q = st_q.q;
        endcase
        if (stall) begin
            st_d.q = st_q.q;
        end
        if (SYNC_CLR && sync_clr) begin
            st_d.q = '0;
        end
    end

    assign q_next   = st_d.q;
    assign changing = ((mode != USR_HOLD) && !stall) || (SYNC_CLR && sync_clr);
    assign q        = st_q.q;

    // edge-triggered storage, clear acts without clock
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

endmodule : usr_shreg

`default_nettype wire

// ---- usr_top.sv ----
// top of the shift and storage register block: narrow and wide registers,
// pin synchronisers, apb control and status, snapshot stream of the wide register
// assumes pins arrive asynchronous to pclk; clear_n also clears at once
`timescale 1ns/10ps
`default_nettype none
`include "usr_map.svh"

module usr_top #(
    parameter int AW         = 12,
    parameter bit SYNC_CLR   = 1'b0,
    parameter int BUF_DEPTH  = 2
) (
    // apb slave
    input  wire logic                    pclk,
    input  wire logic                    presetn,
    input  wire logic                    psel,
    input  wire logic                    penable,
    input  wire logic                    pwrite,
    input  wire logic [AW-1:0]           paddr,
    input  wire logic [31:0]             pwdata,
    output logic      [31:0]             prdata,
    output logic                         pready,
    output logic                         pslverr,
    // mode and clear pins
    input  wire logic                    mode_sel_lo,
    input  wire logic                    mode_sel_hi,
    input  wire logic                    clear_n,
    // narrow register pins
    input  wire logic                    nar_sr_in,
    input  wire logic                    nar_sl_in,
    input  wire logic [`USR_NAR_W-1:0]   nar_par_in,
    output logic      [`USR_NAR_W-1:0]   nar_q,
    // wide register shared pins
    input  wire logic [`USR_WIDE_W-1:0]  wide_io_in,
    output logic      [`USR_WIDE_W-1:0]  wide_io_out,
    output logic      [`USR_WIDE_W-1:0]  wide_io_oe_n,
    input  wire logic                    oe_a_n,
    input  wire logic                    oe_b_n,
    // wide register serial ports
    input  wire logic                    wide_sr_in,
    input  wire logic                    wide_sl_in,
    output logic                         first_stage_out,
    output logic                         last_stage_out,
    // snapshot stream of wide contents
    output logic                         snap_valid,
    input  wire logic                    snap_ready,
    output logic      [`USR_WIDE_W-1:0]  snap_data
);
    import usr_pkg::*;

    localparam int NW = `USR_NAR_W;
    localparam int WW = `USR_WIDE_W;

    // whole state of this module
    typedef struct packed {
        usr_pins_t   meta;
        usr_pins_t   sync;
        usr_ctrl_t   ctrl;
        logic        drop;
        logic        drv_n;
        logic [31:0] rdata;
        logic        slverr;
    } usr_top_st_t;

    // synchroniser starts at the idle pin levels: no drive or clear just after reset
    localparam usr_pins_t PINS_IDLE = '{
        clear_n: 1'b1,
        oe_a_n:  1'b1,
        oe_b_n:  1'b1,
        default: '0
    };

    localparam usr_top_st_t ST_RST = '{
        meta:   PINS_IDLE,
        sync:   PINS_IDLE,
        ctrl:   `USR_CTRL_RST,
        drop:   1'b0,
        drv_n:  1'b1,
        rdata:  32'h0000_0000,
        slverr: 1'b0
    };

    usr_top_st_t st_q;
    usr_top_st_t st_d;

    usr_pins_t   pins_now;
    usr_mode_t   mode_eff;
    logic        nar_arst_n;
    logic        wide_arst_n;
    logic        wide_sync_clr;
    logic        wide_stall;
    logic [WW-1:0] wide_q;
    logic [WW-1:0] wide_q_next;
    logic        wide_changing;
    logic [NW-1:0] nar_q_int;
    logic        buf_in_ready;
    logic        buf_full;
    logic        setup_ph;
    logic        wr_acc;
    logic        hit_ctrl;
    logic        hit_stat;
    logic [31:0] stat_word;

    // gather raw pin levels for the synchroniser
    always_comb begin
        pins_now.mode_sel_hi = mode_sel_hi;
        pins_now.mode_sel_lo = mode_sel_lo;
        pins_now.clear_n     = clear_n;
        pins_now.nar_sr_in   = nar_sr_in;
        pins_now.nar_sl_in   = nar_sl_in;
        pins_now.wide_sr_in  = wide_sr_in;
        pins_now.wide_sl_in  = wide_sl_in;
        pins_now.nar_par     = nar_par_in;
        pins_now.wide_par    = wide_io_in;
        pins_now.oe_a_n      = oe_a_n;
        pins_now.oe_b_n      = oe_b_n;
    end

    // software may take over the mode from the pins
    always_comb begin
        if (st_q.ctrl.ovr) begin
            mode_eff = st_q.ctrl.mode;
        end else begin
            mode_eff = usr_mode_t'({st_q.sync.mode_sel_hi, st_q.sync.mode_sel_lo});
        end
    end

    // clear pin reaches the narrow flops directly, and the wide ones unless SYNC_CLR, which takes it through the synchroniser
    assign nar_arst_n    = presetn & clear_n;
    assign wide_arst_n   = SYNC_CLR ? presetn : (presetn & clear_n);
    assign wide_sync_clr = !st_q.sync.clear_n;

    // a full snapshot buffer holds the wide register when stalling is on
    assign wide_stall = st_q.ctrl.stall_en && !buf_in_ready;

    // narrow four-stage register
    usr_shreg #(
        .W        (NW),
        .SYNC_CLR (1'b0)
    ) u_nar (
        .clk      (pclk),
        .arst_n   (nar_arst_n),
        .sync_clr (1'b0),
        .stall    (1'b0),
        .mode     (mode_eff),
        .sr_in    (st_q.sync.nar_sr_in),
        .sl_in    (st_q.sync.nar_sl_in),
        .par_in   (st_q.sync.nar_par),
        .q_next   (),
        .changing (),
        .q        (nar_q_int)
    );

    // wide eight-stage register on the shared pins
    usr_shreg #(
        .W        (WW),
        .SYNC_CLR (SYNC_CLR)
    ) u_wide (
        .clk      (pclk),
        .arst_n   (wide_arst_n),
        .sync_clr (wide_sync_clr),
        .stall    (wide_stall),
        .mode     (mode_eff),
        .sr_in    (st_q.sync.wide_sr_in),
        .sl_in    (st_q.sync.wide_sl_in),
        .par_in   (st_q.sync.wide_par),
        .q_next   (wide_q_next),
        .changing (wide_changing),
        .q        (wide_q)
    );

    // every clocked change of the wide register is offered to the stream
    usr_buf2 #(
        .W     (WW),
        .DEPTH (BUF_DEPTH)
    ) u_buf (
        .clk       (pclk),
        .rst_n     (presetn),
        .in_valid  (wide_changing),
        .in_ready  (buf_in_ready),
        .in_data   (wide_q_next),
        .out_valid (snap_valid),
        .out_ready (snap_ready),
        .out_data  (snap_data),
        .full      (buf_full)
    );

    // apb decode
    assign setup_ph = psel && !penable;
    assign wr_acc   = psel && penable && pwrite;
    assign hit_ctrl = (paddr[AW-1:2] == (AW-2)'(`USR_CTRL_OFF >> 2));
    assign hit_stat = (paddr[AW-1:2] == (AW-2)'(`USR_STAT_OFF >> 2));

    // status word: contents and flags
    always_comb begin
        stat_word = 32'h0000_0000;
        stat_word[`USR_STAT_WIDE_LSB +: WW] = wide_q;
        stat_word[`USR_STAT_NAR_LSB +: NW]  = nar_q_int;
        stat_word[`USR_STAT_DROP_BIT]       = st_q.drop;
        stat_word[`USR_STAT_FULL_BIT]       = buf_full;
        stat_word[`USR_STAT_DRV_BIT]        = !st_q.drv_n;
    end

    // next state: synchroniser, drive enable, registers, read data
    always_comb begin
        st_d      = st_q;
        st_d.meta = pins_now;
        st_d.sync = st_q.meta;
        // pins are driven only while both enables are low
        st_d.drv_n = st_q.sync.oe_a_n || st_q.sync.oe_b_n;
        // read data is captured in the setup cycle
        if (setup_ph) begin
            st_d.slverr = !(hit_ctrl || hit_stat);
            if (hit_ctrl) begin
                st_d.rdata = {28'h0000_000, st_q.ctrl};
            end else if (hit_stat) begin
                st_d.rdata = stat_word;
            end else begin
                st_d.rdata = 32'h0000_0000;
            end
        end
        // writes take effect at the access edge
        if (wr_acc && hit_ctrl) begin
            st_d.ctrl.ovr      = pwdata[`USR_CTRL_OVR_BIT];
            st_d.ctrl.mode     = usr_mode_t'(pwdata[`USR_CTRL_MODE_LSB +: 2]);
            st_d.ctrl.stall_en = pwdata[`USR_CTRL_STALL_BIT];
        end
        if (wr_acc && hit_stat && pwdata[`USR_STAT_DROP_BIT]) begin
            st_d.drop = 1'b0;
        end
        // a lost snapshot wins over a clear in the same cycle
        if (wide_changing && !buf_in_ready) begin
            st_d.drop = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q <= ST_RST;
        end else begin
            st_q <= st_d;
        end
    end

    // outputs
    assign pready          = 1'b1;
    assign prdata          = st_q.rdata;
    assign pslverr         = st_q.slverr;
    assign nar_q           = nar_q_int;
    assign wide_io_out     = wide_q;
    assign wide_io_oe_n    = {WW{st_q.drv_n}};
    assign first_stage_out = wide_q[0];
    assign last_stage_out  = wide_q[WW-1];

endmodule : usr_top

`default_nettype wire
